/* File: verilog/uart_sig_pkg.sv */
package uart_sig_pkg;
  localparam int NUM_CH = 2;
  localparam int EVT_W = 4;
  // register byte offsets
  localparam logic [7:0] FIFO_CTRL_OFS = 8'h00;
  localparam logic [7:0] MODEM_CTRL_OFS = 8'h04;
  localparam logic [7:0] MODEM_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_EN_OFS = 8'h0C;
  localparam logic [7:0] CH_OFS_MASK = 8'h1F;
  localparam logic [7:0] CH_AREA_MASK = 8'hC0;
  localparam logic [7:0] CH_AREA = 8'h00;
  localparam logic [7:0] EVT_STAT_OFS = 8'h40;
  localparam logic [7:0] EVT_MASK_OFS = 8'h44;
  localparam int CH_SEL_BIT = 5;
  // field positions
  localparam int FIFO_EN_POS = 0;
  localparam int DMA_SEL_POS = 3;
  localparam int RTS_POS = 1;
  localparam int LOOP_POS = 4;
  localparam int AUTO_RTS_POS = 5;
  localparam int RING_TRAILING_EDGE_FLAG_POS = 2;
  localparam int RI_POS = 6;
  localparam int MSI_EN_POS = 3;
  localparam int EVT_RING_POS = 0;
  localparam int EVT_DMA_POS = 2;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [EVT_W-1:0] EVT_RST = 4'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef struct packed {
    logic rx_present;
    logic rx_trigger;
    logic rx_timeout;
    logic rx_threshold;
    logic uart_irq;
  } chan_in_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_req_type;
endpackage : uart_sig_pkg

/* File: verilog/uart_rx_dma_modem_signals.sv */
`timescale 1ns/10ps
// Functional notes
// [R01] dma mode 0: ready output low while any receive character is held
// [R02] dma mode 0: ready output goes high once receive storage is empty
// [R03] dma mode 1: ready output goes low on trigger level or timeout
// [R04] dma mode 1: ready stays low until storage empty, then goes high
// [R05] mode 1 only when fifo enabled and dma select set; else mode 0
// [R06] modem status bit 6 shows the current ring indicator level
// [R07] modem status bit 2 flags ring rise since last status read
// [R08] ring rise with modem-status interrupt enabled raises channel irq
// [R09] rts active from control bit 1; inactive on reset, loop, bit clear
// [R10] auto rts: receiver threshold logic drives rts inactive
// [R11] reset high clears internal registers but sets ready and rts high; host drives it high
// [R12] channel irq output high while that channel has a pending interrupt
// [R13] rts active level is low, inactive level high
module uart_rx_dma_modem_signals
  import uart_sig_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic [1:0] hresp,
  input wire chan_in_type chan_in_ch0,
  input wire chan_in_type chan_in_ch1,
  input wire logic ring_indicator_in_ch0,
  input wire logic ring_indicator_in_ch1,
  output logic rx_dma_ready_n_ch0,
  output logic rx_dma_ready_n_ch1,
  output logic request_to_send_out_ch0,
  output logic request_to_send_out_ch1,
  output logic channel_irq_out_ch0,
  output logic channel_irq_out_ch1,
  output logic irq
);

  chan_in_type chin [NUM_CH];
  logic [NUM_CH-1:0] ri_in;
  ahb_req_type req_reg;
  logic rd_done_reg;
  logic [31:0] hrdata_reg;
  logic [7:0] fifo_ctrl_reg [NUM_CH];
  logic [7:0] modem_ctrl_reg [NUM_CH];
  logic [7:0] irq_en_reg [NUM_CH];
  logic [NUM_CH-1:0] ri_prev_reg;
  logic [NUM_CH-1:0] ring_trailing_edge_flag_reg;
  logic [NUM_CH-1:0] rdy_active_reg;
  logic [NUM_CH-1:0] rx_rdy_n_reg;
  logic [NUM_CH-1:0] rx_rdy_n_next;
  logic [NUM_CH-1:0] rts_n_reg;
  logic [NUM_CH-1:0] rts_n_next;
  logic [NUM_CH-1:0] ch_irq_reg;
  logic [NUM_CH-1:0] mode1;
  logic [NUM_CH-1:0] ring_rise;
  logic [NUM_CH-1:0] msr_rd;
  logic [EVT_W-1:0] evt_stat_reg;
  logic [EVT_W-1:0] evt_mask_reg;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_w1c;
  logic addr_phase;
  logic rd_pending;
  logic wr_fire;
  logic req_ch;
  logic req_in_ch;
  logic [7:0] req_local;
  logic [31:0] rd_mux;

  assign chin[0] = chan_in_ch0;
  assign chin[1] = chan_in_ch1;
  assign ri_in = {ring_indicator_in_ch1, ring_indicator_in_ch0};

  // ahb-lite slave
  assign addr_phase = hsel && hready && htrans[1];
  assign rd_pending = req_reg.valid && !req_reg.write && !rd_done_reg;
  assign wr_fire = req_reg.valid && req_reg.write;
  assign req_ch = req_reg.addr[CH_SEL_BIT];
  assign req_in_ch = (req_reg.addr & CH_AREA_MASK) == CH_AREA;
  assign req_local = req_reg.addr & CH_OFS_MASK;
  assign hreadyout = !rd_pending;
  assign hrdata = hrdata_reg;
  assign hresp = HRESP_OKAY;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin // R11
      req_reg <= '0;
    end else if (addr_phase) begin
      req_reg.valid <= 1'b1;
      req_reg.write <= hwrite;
      req_reg.addr <= haddr[7:0];
    end else if (hready) begin
      req_reg.valid <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_done_reg <= 1'b0;
    end else if (addr_phase) begin
      rd_done_reg <= 1'b0;
    end else if (rd_pending) begin
      rd_done_reg <= 1'b1;
    end
  end

  always_comb begin
    rd_mux = RDATA_RST;
    if (req_in_ch) begin
      case (req_local)
        FIFO_CTRL_OFS: rd_mux[7:0] = fifo_ctrl_reg[req_ch];
        MODEM_CTRL_OFS: rd_mux[7:0] = modem_ctrl_reg[req_ch];
        MODEM_STAT_OFS: begin
          rd_mux[RI_POS] = ri_in[req_ch]; // R06
          rd_mux[RING_TRAILING_EDGE_FLAG_POS] = ring_trailing_edge_flag_reg[req_ch]; // R07
        end
        IRQ_EN_OFS: rd_mux[7:0] = irq_en_reg[req_ch];
        default: rd_mux = RDATA_RST;
      endcase
    end else if (req_reg.addr == EVT_STAT_OFS) begin
      rd_mux[EVT_W-1:0] = evt_stat_reg;
    end else if (req_reg.addr == EVT_MASK_OFS) begin
      rd_mux[EVT_W-1:0] = evt_mask_reg;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hrdata_reg <= RDATA_RST;
    end else if (rd_pending) begin
      hrdata_reg <= rd_mux;
    end
  end

  // channel control registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin // R11
      for (int i = 0; i < NUM_CH; i++) begin
        fifo_ctrl_reg[i] <= CTRL_RST;
        modem_ctrl_reg[i] <= CTRL_RST;
        irq_en_reg[i] <= CTRL_RST;
      end
    end else if (wr_fire && req_in_ch) begin
      case (req_local)
        FIFO_CTRL_OFS: fifo_ctrl_reg[req_ch] <= hwdata[7:0];
        MODEM_CTRL_OFS: modem_ctrl_reg[req_ch] <= hwdata[7:0];
        IRQ_EN_OFS: irq_en_reg[req_ch] <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // per-channel signalling
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      mode1[i] = fifo_ctrl_reg[i][FIFO_EN_POS]
                 && fifo_ctrl_reg[i][DMA_SEL_POS]; // R05
      ring_rise[i] = ri_in[i] && !ri_prev_reg[i];
      msr_rd[i] = rd_pending && req_in_ch && (req_ch == 1'(i))
                  && (req_local == MODEM_STAT_OFS);
      if (mode1[i]) begin
        rx_rdy_n_next[i] = !(chin[i].rx_present
          && (rdy_active_reg[i] || chin[i].rx_trigger
              || chin[i].rx_timeout)); // R03 R04
      end else begin
        rx_rdy_n_next[i] = !chin[i].rx_present; // R01 R02
      end
      if (modem_ctrl_reg[i][LOOP_POS]) begin
        rts_n_next[i] = 1'b1; // R09
      end else if (modem_ctrl_reg[i][AUTO_RTS_POS]
                   && chin[i].rx_threshold) begin
        rts_n_next[i] = 1'b1; // R10
      end else begin
        rts_n_next[i] = !modem_ctrl_reg[i][RTS_POS]; // R09 R13
      end
    end
  end

  // mode 1 burst latch, held until storage drains
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdy_active_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (!chin[i].rx_present) begin
          rdy_active_reg[i] <= 1'b0; // R04
        end else if (chin[i].rx_trigger || chin[i].rx_timeout) begin
          rdy_active_reg[i] <= 1'b1; // R03
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_rdy_n_reg <= '1;
    end else begin
      rx_rdy_n_reg <= rx_rdy_n_next;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rts_n_reg <= '1; // R09 R13
    end else begin
      rts_n_reg <= rts_n_next;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ri_prev_reg <= '0;
    end else begin
      ri_prev_reg <= ri_in;
    end
  end

  // edge flag: new rise wins over the read clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ring_trailing_edge_flag_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (ring_rise[i]) begin
          ring_trailing_edge_flag_reg[i] <= 1'b1; // R07
        end else if (msr_rd[i]) begin
          ring_trailing_edge_flag_reg[i] <= 1'b0; // R07
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ch_irq_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        ch_irq_reg[i] <= chin[i].uart_irq
          || (irq_en_reg[i][MSI_EN_POS] && ring_trailing_edge_flag_reg[i]); // R08 R12
      end
    end
  end

  // sticky event status, write one to clear, set wins
  assign evt_set[EVT_RING_POS +: NUM_CH] = ring_rise;
  assign evt_set[EVT_DMA_POS +: NUM_CH] = rx_rdy_n_reg & ~rx_rdy_n_next;
  assign evt_w1c = (wr_fire && req_reg.addr == EVT_STAT_OFS)
                   ? hwdata[EVT_W-1:0] : EVT_RST;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      evt_stat_reg <= EVT_RST;
    end else begin
      evt_stat_reg <= (evt_stat_reg & ~evt_w1c) | evt_set;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      evt_mask_reg <= EVT_RST;
    end else if (wr_fire && req_reg.addr == EVT_MASK_OFS) begin
      evt_mask_reg <= hwdata[EVT_W-1:0];
    end
  end

  assign irq = |(evt_stat_reg & evt_mask_reg);
  assign rx_dma_ready_n_ch0 = rx_rdy_n_reg[0];
  assign rx_dma_ready_n_ch1 = rx_rdy_n_reg[1];
  assign request_to_send_out_ch0 = rts_n_reg[0];
  assign request_to_send_out_ch1 = rts_n_reg[1];
  assign channel_irq_out_ch0 = ch_irq_reg[0];
  assign channel_irq_out_ch1 = ch_irq_reg[1];

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
    property p_mode0_low;
      !mode1[g] && chin[g].rx_present |=> !rx_rdy_n_reg[g];
    endproperty
    a_mode0_low: assert property (p_mode0_low) // R01
      else $error("mode 0 ready not low with data held");

    property p_mode0_high;
      !mode1[g] && !chin[g].rx_present |=> rx_rdy_n_reg[g];
    endproperty
    a_mode0_high: assert property (p_mode0_high) // R02
      else $error("mode 0 ready not high when empty");

    property p_mode1_go;
      mode1[g] && chin[g].rx_present
        && (chin[g].rx_trigger || chin[g].rx_timeout)
        |=> !rx_rdy_n_reg[g];
    endproperty
    a_mode1_go: assert property (p_mode1_go) // R03
      else $error("mode 1 ready not low on trigger");

    property p_mode1_hold;
      mode1[g] && rdy_active_reg[g] && chin[g].rx_present
        |=> rdy_active_reg[g] && (!mode1[g] || !rx_rdy_n_next[g]
            || !chin[g].rx_present);
    endproperty
    a_mode1_hold: assert property (p_mode1_hold) // R04
      else $error("mode 1 burst dropped before empty");

    property p_nonfifo;
      !fifo_ctrl_reg[g][FIFO_EN_POS] && chin[g].rx_present
        |=> !rx_rdy_n_reg[g];
    endproperty
    a_nonfifo: assert property (p_nonfifo) // R05
      else $error("non-fifo mode not using dma mode 0");

    property p_ri_read;
      msr_rd[g] |=> hrdata_reg[RI_POS] == $past(ri_in[g]);
    endproperty
    a_ri_read: assert property (p_ri_read) // R06
      else $error("ring level not returned on status read");

    property p_ring_trailing_edge_flag;
      ring_rise[g] |=> ring_trailing_edge_flag_reg[g] ##1 (ring_trailing_edge_flag_reg[g] || msr_rd[g]
        || $past(msr_rd[g]));
    endproperty
    a_ring_trailing_edge_flag: assert property (p_ring_trailing_edge_flag) // R07
      else $error("ring edge flag not set");

    property p_ring_irq;
      ring_rise[g] && irq_en_reg[g][MSI_EN_POS]
        ##1 irq_en_reg[g][MSI_EN_POS] |=> ch_irq_reg[g];
    endproperty
    a_ring_irq: assert property (p_ring_irq) // R08
      else $error("ring edge did not raise channel irq");

    property p_rts_loop;
      modem_ctrl_reg[g][LOOP_POS] |=> rts_n_reg[g];
    endproperty
    a_rts_loop: assert property (p_rts_loop) // R09
      else $error("rts active in loop mode");

    property p_rts_on;
      !modem_ctrl_reg[g][LOOP_POS] && !modem_ctrl_reg[g][AUTO_RTS_POS]
        && modem_ctrl_reg[g][RTS_POS] |=> !rts_n_reg[g];
    endproperty
    a_rts_on: assert property (p_rts_on) // R13
      else $error("rts not driven low when requested");

    property p_auto_rts;
      modem_ctrl_reg[g][AUTO_RTS_POS] && chin[g].rx_threshold
        |=> rts_n_reg[g];
    endproperty
    a_auto_rts: assert property (p_auto_rts) // R10
      else $error("auto rts did not go inactive");

    property p_uart_irq;
      chin[g].uart_irq |=> ch_irq_reg[g];
    endproperty
    a_uart_irq: assert property (p_uart_irq) // R12
      else $error("channel irq missing while pending");

    property p_burst;
      mode1[g] && rx_rdy_n_reg[g] ##1 !rx_rdy_n_reg[g] [*3];
    endproperty
    c_burst: cover property (p_burst);

    property p_ring_seen;
      ring_rise[g] ##1 ring_trailing_edge_flag_reg[g] ##[1:8] msr_rd[g];
    endproperty
    c_ring_seen: cover property (p_ring_seen);

    property p_auto_hit;
      !rts_n_reg[g] ##1 modem_ctrl_reg[g][AUTO_RTS_POS] && rts_n_reg[g];
    endproperty
    c_auto_hit: cover property (p_auto_hit);
  end

  property p_irq_out;
    evt_set != EVT_RST ##1 (evt_stat_reg & evt_mask_reg) != EVT_RST
      |-> irq;
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("unmasked event did not raise irq");

  property p_read_wait;
    addr_phase && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read data phase not one wait state");

  property p_evt_clear;
    wr_fire && req_reg.addr == EVT_STAT_OFS && hwdata[EVT_W-1:0] != EVT_RST
      && evt_set == EVT_RST
      |=> (evt_stat_reg & $past(hwdata[EVT_W-1:0])) == EVT_RST;
  endproperty
  a_evt_clear: assert property (p_evt_clear)
    else $error("status bit not cleared by write one");

  c_irq: cover property (!irq ##1 irq);

endmodule : uart_rx_dma_modem_signals

/* File: testbench/rx_feed_model.sv */
`timescale 1ns/10ps
module rx_feed_model
  import uart_sig_pkg::*;
#(
  parameter int TRIG = 4,
  parameter int THR = 6
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ready_n,
  input wire logic prompt,
  input wire logic take,
  input wire logic [3:0] add,
  input wire logic tmo,
  input wire logic other_irq,
  output chan_in_type chan
);
  logic [4:0] count_reg;
  logic drain;
  // dma side only takes a character while the request is low
  assign drain = !ready_n && (prompt || take) && count_reg != 5'h00;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_reg <= 5'h00;
    end else begin
      count_reg <= count_reg + 5'(add) - 5'(drain);
    end
  end
  assign chan.rx_present = count_reg != 5'h00;
  assign chan.rx_trigger = count_reg >= 5'(TRIG);
  assign chan.rx_timeout = tmo;
  assign chan.rx_threshold = count_reg >= 5'(THR);
  assign chan.uart_irq = other_irq;
endmodule : rx_feed_model

/* File: testbench/uart_rx_dma_modem_signals_tb.sv */
`timescale 1ns/10ps
module uart_rx_dma_modem_signals_tb;
  import uart_sig_pkg::*;
  localparam int LIMIT = 6000;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic hready;
  logic hreadyout;
  logic irq;
  logic [31:0] hrdata;
  logic [1:0] hresp;
  chan_in_type chan [2];
  logic [1:0] ri = 2'h0;
  logic [1:0] prompt = 2'h0;
  logic [1:0] take = 2'h0;
  logic [1:0] tmo = 2'h0;
  logic [1:0] oirq = 2'h0;
  logic [7:0] add_v = 8'h00;
  logic [1:0] rdy;
  logic [1:0] rts;
  logic [1:0] cirq;
  logic [6:0] pins;
  logic [13:0] pe;
  logic rd_phase = 1'b0;
  logic pin_req = 1'b0;
  int cycles = 0;
  int miscompares = 0;
  int n_compared = 0;
  integer seed;
  logic [31:0] rq [$];
  logic [13:0] pq [$];

  always #5 mclk = ~mclk;
  assign hready = hreadyout;
  assign pins = {irq, cirq, rts, rdy};

  uart_rx_dma_modem_signals dut (.mclk(mclk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .chan_in_ch0(chan[0]),
    .chan_in_ch1(chan[1]), .ring_indicator_in_ch0(ri[0]),
    .ring_indicator_in_ch1(ri[1]), .rx_dma_ready_n_ch0(rdy[0]),
    .rx_dma_ready_n_ch1(rdy[1]), .request_to_send_out_ch0(rts[0]),
    .request_to_send_out_ch1(rts[1]), .channel_irq_out_ch0(cirq[0]),
    .channel_irq_out_ch1(cirq[1]), .irq(irq));

  for (genvar g = 0; g < 2; g++) begin : g_feed
    rx_feed_model feed (.mclk(mclk), .rst(rst), .ready_n(rdy[g]),
      .prompt(prompt[g]), .take(take[g]), .add(add_v[g*4+:4]),
      .tmo(tmo[g]), .other_irq(oirq[g]), .chan(chan[g]));
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // watcher: read data phases and requested pin samples
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      conclude();
    end else begin
      if (rd_phase && hready === 1'b1) begin
        check(hrdata, rq.pop_front());
        check(32'(hresp), 32'(HRESP_OKAY));
      end
      if (hready === 1'b1)
        rd_phase <= hsel && htrans[1] && !hwrite;
      if (pin_req) begin
        pe = pq.pop_front();
        check(32'(pins & pe[13:7]), 32'(pe[6:0]));
      end
    end
  end

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic pexp(input logic [6:0] m, input logic [6:0] e);
    repeat (3) @(posedge mclk);
    pq.push_back({m, e & m});
    pin_req <= 1'b1;
    @(posedge mclk);
    pin_req <= 1'b0;
  endtask : pexp

  task automatic addc(input int c, input logic [3:0] n);
    add_v[c*4+:4] <= n;
    @(posedge mclk);
    add_v[c*4+:4] <= 4'h0;
  endtask : addc

  task automatic takec(input int c, input int k);
    if (k != 0) begin
      take[c] <= 1'b1;
      repeat (k) @(posedge mclk);
      take[c] <= 1'b0;
    end
  endtask : takec

  initial begin
    logic [7:0] b;
    logic [7:0] fc;
    logic [6:0] mr;
    logic [6:0] ms;
    logic [6:0] mi;
    logic [7:0] mc_tab [4];
    logic [3:0] n;
    seed = 32'h23DE2282;
    mc_tab = '{8'h02, 8'h00, 8'h12, 8'h22};
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    pexp(7'h7F, 7'h0F);
    for (int c = 0; c < 2; c++) begin
      b = 8'(c * 32);
      mr = 7'h01 << c;
      ms = 7'h04 << c;
      mi = 7'h10 << c;
      rd(b + FIFO_CTRL_OFS, 32'h0000_0000);
      rd(b + MODEM_CTRL_OFS, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
        wr(b + MODEM_CTRL_OFS, {24'h000000, mc_tab[i]});
        pexp(ms, (i == 0 || i == 3) ? 7'h00 : ms);
      end
      addc(c, 4'h7);
      pexp(ms | mr, ms);
      wr(b + MODEM_CTRL_OFS, 32'h0000_0002);
      pexp(ms, 7'h00);
      prompt[c] <= 1'b1;
      // seven characters drain one per cycle before ready returns high
      repeat (6) @(posedge mclk);
      pexp(ms | mr, mr);
      prompt[c] <= 1'b0;
      wr(b + MODEM_CTRL_OFS, 32'h0000_0000);
      for (int f = 0; f < 4; f++) begin
        fc = (f[1] ? 8'h08 : 8'h00) | {7'h00, f[0]};
        wr(b + FIFO_CTRL_OFS, {24'h000000, fc});
        n = 4'(1 + {$random(seed)} % 3);
        addc(c, n);
        pexp(mr, (fc == 8'h09) ? mr : 7'h00);
        if (fc == 8'h09) begin
          addc(c, 4'h3);
          n = n + 4'h3;
          pexp(mr, 7'h00);
        end
        takec(c, int'(n) - 1);
        pexp(mr, 7'h00);
        takec(c, 1);
        pexp(mr, mr);
      end
      addc(c, 4'h1);
      tmo[c] <= 1'b1;
      pexp(mr, 7'h00);
      tmo[c] <= 1'b0;
      takec(c, 1);
      pexp(mr, mr);
      wr(b + FIFO_CTRL_OFS, 32'h0000_0000);
      wr(b + IRQ_EN_OFS, 32'h0000_0008);
      ri[c] <= 1'b1;
      pexp(mi, mi);
      rd(b + MODEM_STAT_OFS, 32'h0000_0044);
      pexp(mi, 7'h00);
      rd(b + MODEM_STAT_OFS, 32'h0000_0040);
      ri[c] <= 1'b0;
      wr(b + MODEM_STAT_OFS, 32'h0000_00FF);
      rd(b + MODEM_STAT_OFS, 32'h0000_0000);
      oirq[c] <= 1'b1;
      pexp(mi, mi);
      oirq[c] <= 1'b0;
    end
    rd(EVT_STAT_OFS, 32'h0000_000F);
    wr(EVT_MASK_OFS, 32'h0000_0001);
    pexp(7'h40, 7'h40);
    wr(EVT_STAT_OFS, 32'h0000_0001);
    pexp(7'h40, 7'h00);
    wr(EVT_MASK_OFS, 32'h0000_0004);
    rd(EVT_MASK_OFS, 32'h0000_0004);
    pexp(7'h40, 7'h40);
    wr(EVT_STAT_OFS, 32'h0000_000E);
    rd(EVT_STAT_OFS, 32'h0000_0000);
    pexp(7'h40, 7'h00);
    wr(8'h80, 32'hFFFF_FFFF);
    rd(8'h80, 32'h0000_0000);
    wr(MODEM_CTRL_OFS, 32'h0000_0002);
    pexp(7'h04, 7'h00);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    pexp(7'h7F, 7'h0F);
    rd(MODEM_CTRL_OFS, 32'h0000_0000);
    repeat (3) @(posedge mclk);
    conclude();
  end
endmodule : uart_rx_dma_modem_signals_tb
